//--- src/sync_2ff.v
// Two flip-flop synchroniser for levels coming from outside the clock domain.
`timescale 1ns/1ps
module sync_2ff
#(
   parameter W = 1
)
(
   // Clock and reset
   input wire i_clk,
   input wire i_reset_n,
   // Data
   input wire [W-1:0] i_async,
   output wire [W-1:0] o_sync
);

   reg [W-1:0] meta_reg;
   reg [W-1:0] sync_reg;

   always @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         meta_reg <= {W{1'b0}};
         sync_reg <= {W{1'b0}};
      end
      else
      begin
         meta_reg <= i_async;
         sync_reg <= meta_reg;
      end
   end

   assign o_sync = sync_reg;

endmodule

//--- src/watchdog_write_sync.v
// Watchdog unit with fast-clock register writes synchronised to slow ticks.
`timescale 1ns/1ps
`include "watchdog_write_sync_defs.vh"

module watchdog_write_sync
(
   // Clock and reset
   input wire i_clk,
   input wire i_reset_n,
   // Slow clock sources
   input wire i_xtal_clk,
   input wire i_clk_sel,
   // Processor write port
   input wire i_wr_en,
   input wire i_wr_sel,
   input wire [7:0] i_wr_data,
   output wire o_wr_ready,
   output reg o_wr_done,
   // Watchdog state
   output reg o_slow_tick,
   output reg o_counter_clk,
   output reg [`CFG_W-1:0] o_config,
   output reg [`WD_W-1:0] o_wd_count,
   output reg o_wd_expired
);

   wire xtal_sync;
   reg xtal_prev_reg;
   reg [`PRESCALE_W-1:0] div_reg;
   reg [`PRESCALE_W-1:0] div_next;
   reg div_tick;
   wire xtal_tick;
   wire slow_tick;
   reg [3:0] timer_reg;
   reg [3:0] timer_next;
   reg timer_underflow;
   wire counter_clk;
   reg pend_reg;
   reg sel_hold_reg;
   reg [7:0] data_hold_reg;
   reg [`WD_W-1:0] wd_next;
   reg expired_next;
   wire apply_write;
   reg pend_next;
   reg sel_hold_next;
   reg [7:0] data_hold_next;

   // The crystal input comes from a pin, so it is synchronised first.
   sync_2ff #(.W(1)) u_xtal_sync
   (
      .i_clk(i_clk),
      .i_reset_n(i_reset_n),
      .i_async(i_xtal_clk),
      .o_sync(xtal_sync)
   );

   assign xtal_tick = xtal_sync & ~xtal_prev_reg;

   // The slow tick is a one-cycle enable, not a clock, which keeps one domain.
   always @*
   begin
      div_tick = (div_reg == 8'h00);
      if (div_tick)
      begin
         div_next = `PRESCALE_RELOAD;
      end
      else
      begin
         div_next = div_reg - 8'h01;
      end
   end

   assign slow_tick = i_clk_sel ? xtal_tick : div_tick;

   // The prescale timer counts slow ticks and reloads from the configuration.
   always @*
   begin
      timer_next = timer_reg;
      timer_underflow = 1'b0;
      if (slow_tick)
      begin
         if (timer_reg == 4'h0)
         begin
            timer_underflow = 1'b1;
            timer_next = o_config[`CFG_RELOAD_MSB:`CFG_RELOAD_LSB];
         end
         else
         begin
            timer_next = timer_reg - 4'h1;
         end
      end
   end

   assign counter_clk = o_config[`CFG_SRC_BIT] ? timer_underflow : slow_tick;

   // A held write is applied on the first slow tick after it was taken.
   // That is at most one counter clock later, well inside the limit of four.
   assign apply_write = pend_reg & slow_tick;

   // A second write is refused while one is pending, and is lost unless the writer holds it until ready.
   assign o_wr_ready = ~pend_reg;

   // Watchdog counter: a service with the right key reloads it; a wrong key
   // or a counter clock at zero sets the expired flag, which stays until reset.
   always @*
   begin
      wd_next = o_wd_count;
      expired_next = o_wd_expired;
      if (apply_write && (sel_hold_reg == `WR_SEL_MATCH))
      begin
         if (data_hold_reg == `SERVICE_KEY)
         begin
            wd_next = `WD_RELOAD;
         end
         else
         begin
            expired_next = 1'b1;
         end
      end
      else if (counter_clk && !o_wd_expired)
      begin
         if (o_wd_count == 8'h00)
         begin
            expired_next = 1'b1;
         end
         else
         begin
            wd_next = o_wd_count - 8'h01;
         end
      end
   end

   // Slow tick and counter clock state.
   // Both pulses leave through flip-flops, one cycle after the internal enables.
   always @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         xtal_prev_reg <= 1'b0;
         div_reg <= 8'h00;
         timer_reg <= 4'h0;
         o_slow_tick <= 1'b0;
         o_counter_clk <= 1'b0;
      end
      else
      begin
         xtal_prev_reg <= xtal_sync;
         div_reg <= div_next;
         timer_reg <= timer_next;
         o_slow_tick <= slow_tick;
         o_counter_clk <= counter_clk;
      end
   end

   // The written value stays put until the slow side has used it.
   // A write that meets a busy port is dropped, so the writer must watch ready.
   always @*
   begin
      pend_next = pend_reg;
      sel_hold_next = sel_hold_reg;
      data_hold_next = data_hold_reg;
      if (i_wr_en && !pend_reg)
      begin
         pend_next = 1'b1;
         sel_hold_next = i_wr_sel;
         data_hold_next = i_wr_data;
      end
      else if (apply_write)
      begin
         pend_next = 1'b0;
      end
   end

   always @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         pend_reg <= 1'b0;
         sel_hold_reg <= 1'b0;
         data_hold_reg <= 8'h00;
         o_wr_done <= 1'b0;
      end
      else
      begin
         pend_reg <= pend_next;
         sel_hold_reg <= sel_hold_next;
         data_hold_reg <= data_hold_next;
         o_wr_done <= apply_write;
      end
   end

   // Configuration and watchdog state.
   always @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         o_config <= `CFG_RESET;
         o_wd_count <= `WD_RELOAD;
         o_wd_expired <= 1'b0;
      end
      else
      begin
         o_wd_count <= wd_next;
         o_wd_expired <= expired_next;
         if (apply_write && (sel_hold_reg == `WR_SEL_CONFIG))
         begin
            o_config <= data_hold_reg;
         end
      end
   end

endmodule

//--- src/watchdog_write_sync_defs.vh
// Constants shared by the watchdog write synchroniser.
`ifndef WATCHDOG_WRITE_SYNC_DEFS_VH
`define WATCHDOG_WRITE_SYNC_DEFS_VH

// Fast clock and slow clock limits, in kHz.
`define FAST_CLK_KHZ 10000
`define XTAL_CLK_KHZ 32
`define SLOW_CLK_MAX_KHZ 100

// Prescaler divide count, so the derived slow clock never passes the limit.
`define PRESCALE_DIV (`FAST_CLK_KHZ / `SLOW_CLK_MAX_KHZ)
`define PRESCALE_W 8
`define PRESCALE_RELOAD 8'h63

// Write targets.
`define WR_SEL_CONFIG 1'b0
`define WR_SEL_MATCH 1'b1

// Configuration register fields and reset value.
`define CFG_W 8
`define CFG_SRC_BIT 0
`define CFG_RELOAD_LSB 4
`define CFG_RELOAD_MSB 7
`define CFG_RESET 8'h10

// Watchdog counter width, reset value and service key.
`define WD_W 8
`define WD_RELOAD 8'hFF
`define SERVICE_KEY 8'h5C

// Longest allowed write-to-effect delay, in watchdog counter clocks.
`define SYNC_MAX_COUNTER_CLKS 4

`endif

//--- testbench/cpu_writer.sv
// Processor model that issues held writes.
`timescale 1ns/1ps
module cpu_writer
(
   // Handshake
   input wire i_clk,
   input wire i_ready,
   output reg o_wr_en = 1'b0,
   output reg o_wr_sel = 1'b0,
   output reg [7:0] o_wr_data = 8'h00
);
   // The request is held until ready, so a busy block never loses it.
   task write(input s, input [7:0] d);
      begin
         @(negedge i_clk);
         o_wr_en = 1'b1;
         o_wr_sel = s;
         o_wr_data = d;
         while (!i_ready)
            @(negedge i_clk);
         @(negedge i_clk);
         o_wr_en = 1'b0;
         o_wr_data = ~d;
      end
   endtask
endmodule

//--- testbench/watchdog_write_sync_sva.sv
// Port checker for the watchdog write synchroniser.
`timescale 1ns/1ps
module watchdog_write_sync_sva
(
   // Inputs
   input wire i_clk,
   input wire i_reset_n,
   input wire i_clk_sel,
   input wire i_wr_en,
   // Outputs
   input wire o_wr_ready,
   input wire o_wr_done,
   input wire o_slow_tick,
   input wire o_counter_clk,
   input wire [7:0] o_config,
   input wire [7:0] o_wd_count,
   input wire o_wd_expired
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);
   sequence s_take;
      i_wr_en && o_wr_ready;
   endsequence
   chk_take_busy: assert property (s_take |=> !o_wr_ready) else $error("busy");
   chk_apply_bound: assert property (s_take |-> ##[1:320] o_wr_done) else $error("late");
   chk_apply_tick: assert property (o_wr_done |-> o_slow_tick && o_wr_ready)
      else $error("tick");
   chk_prescale_rate: assert property (o_slow_tick && !i_clk_sel |->
      ##100 (o_slow_tick || i_clk_sel)) else $error("rate");
   chk_src_tick: assert property ($stable(o_config) && !o_config[0] && !o_wd_expired
      |-> o_counter_clk == o_slow_tick) else $error("src");
   chk_src_timer: assert property ($stable(o_config) && o_config[0] && o_counter_clk
      |-> o_slow_tick) else $error("timer");
   chk_count_step: assert property (o_counter_clk && !o_wr_done && !$past(o_wd_expired)
      && $past(o_wd_count) != 8'h00 |-> o_wd_count == $past(o_wd_count) - 8'h01)
      else $error("step");
endmodule
bind watchdog_write_sync watchdog_write_sync_sva i_sva (.i_clk(i_clk), .i_reset_n(i_reset_n),
   .i_clk_sel(i_clk_sel), .i_wr_en(i_wr_en), .o_wr_ready(o_wr_ready), .o_wr_done(o_wr_done),
   .o_slow_tick(o_slow_tick), .o_counter_clk(o_counter_clk), .o_config(o_config),
   .o_wd_count(o_wd_count), .o_wd_expired(o_wd_expired));

//--- testbench/watchdog_write_sync_tb_top.sv
// Self-checking bench for the watchdog write synchroniser.
`timescale 1ns/1ps
`include "watchdog_write_sync_defs.vh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin num_errors++; \
   $display("mismatch %0t got %h", $time, a); end end
module watchdog_write_sync_tb_top;
   reg i_clk = 1'b0;
   reg i_reset_n = 1'b0;
   reg xtal = 1'b0;
   reg sel = 1'b0;
   wire en, ws, rdy, done, tick, cclk, exp;
   wire [7:0] wd, cfg, cnt;
   integer num_errors = 0;
   integer check_count = 0;
   integer n;
   always #50 i_clk = ~i_clk;
   always #15625 if (sel) xtal = ~xtal;
   cpu_writer i_cpu (.i_clk(i_clk), .i_ready(rdy), .o_wr_en(en), .o_wr_sel(ws), .o_wr_data(wd));
   watchdog_write_sync i_dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_xtal_clk(xtal),
      .i_clk_sel(sel), .i_wr_en(en), .i_wr_sel(ws), .i_wr_data(wd), .o_wr_ready(rdy),
      .o_wr_done(done), .o_slow_tick(tick), .o_counter_clk(cclk), .o_config(cfg),
      .o_wd_count(cnt), .o_wd_expired(exp));
   task results();
      begin
         $display("errors %0d checks %0d", num_errors, check_count);
         if (num_errors == 0 && check_count > 0)
            $display("All tests passed");
         else
            $display("Some tests failed");
         $finish;
      end
   endtask
   task wait_for(input integer lim);
      begin
         for (n = 0; n < lim && done !== 1'b1; n++)
            @(negedge i_clk);
         `CHK(done, 1'b1)
         `CHK(tick, 1'b1)
      end
   endtask
   // Services well inside the window, so the sync delay cannot push it out.
   task t_service();
      begin
         `CHK(cfg, `CFG_RESET)
         i_cpu.write(`WR_SEL_MATCH, `SERVICE_KEY);
         wait_for(110);
         `CHK(cnt, `WD_RELOAD)
         // The service tick is itself a counter clock, so step past it first.
         @(negedge i_clk);
         for (n = 0; n < 110 && cclk !== 1'b1; n++)
            @(negedge i_clk);
         `CHK(cclk, 1'b1)
         `CHK(cnt, 8'hFE)
      end
   endtask
   task t_pair();
      begin
         i_cpu.write(`WR_SEL_CONFIG, 8'h21);
         `CHK(rdy, 1'b0)
         i_cpu.write(`WR_SEL_CONFIG, 8'h31);
         `CHK(cfg, 8'h21)
         wait_for(110);
         `CHK(cfg, 8'h31)
      end
   endtask
   task t_crystal();
      begin
         sel = 1'b1;
         i_cpu.write(`WR_SEL_CONFIG, 8'h10);
         wait_for(330);
         `CHK(cfg, 8'h10)
      end
   endtask
   task t_bad();
      begin
         i_cpu.write(`WR_SEL_MATCH, 8'hA3);
         wait_for(330);
         @(negedge i_clk);
         `CHK(exp, 1'b1)
      end
   endtask
   initial begin
      repeat (10) @(negedge i_clk);
      i_reset_n = 1'b1;
      t_service();
      t_pair();
      t_crystal();
      t_bad();
      results();
   end
   initial begin
      #500000;
      num_errors++;
      results();
   end
endmodule
